// >>> hw/shpfc_device.sv
/*
  Device end of the serial host port: RS232 host channel with ready/clear flow
  control, logic-level 8N1 channel, and pulse-per-second select.
  Assumes inputs synchronous to clk_sys and a message layer on the user side.
*/
`timescale 1ns/10ps

`include "shpfc_consts.svh"

module shpfc_device
  import shpfc_pkg::*;
#(
  parameter int unsigned DIV = `SHPFC_DIV_TYP,
  parameter int unsigned NAV_DIV = `SHPFC_DIV_TYP
) (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  shpfc_if.device                          link,
  input  wire logic                        use_uart,
  input  wire logic                        sync_sel_b,
  input  wire logic [`SHPFC_DATA_BITS-1:0] tx_data,
  input  wire logic                        tx_valid,
  output logic                             tx_ready,
  output logic [`SHPFC_DATA_BITS-1:0]      rx_data,
  output logic                             rx_valid,
  output logic                             rx_frame_err,
  output logic                             pps_pulse
);

  // Baud rate and counter reloads from the divisor
  localparam int unsigned BAUD = `SHPFC_CLK_HZ / DIV;
  localparam logic [`SHPFC_DIV_W-1:0] DIV_M1 = `SHPFC_DIV_W'(DIV - 1);
  localparam logic [`SHPFC_DIV_W-1:0] DIV_H  = `SHPFC_DIV_W'(DIV / 2);
  localparam logic [`SHPFC_DIV_W-1:0] HAND_M1 = `SHPFC_DIV_W'(`SHPFC_HANDOFF_CYC - 1);

  typedef struct packed {
    shpfc_tx_t              tx;
    shpfc_rx_t              rx;
    logic                   hand;
    logic [`SHPFC_DIV_W-1:0] hand_cnt;
    logic                   sync_q;
    logic                   pps;
  } shpfc_dev_t;

  shpfc_dev_t s;
  shpfc_dev_t next_s;
  logic       line_in;
  logic       clear_ok;
  logic       sync_in;

  assign line_in  = use_uart ? link.uart_line_rx : link.host_line_rx;
  assign clear_ok = use_uart || link.host_clear_in;
  assign sync_in  = sync_sel_b ? link.sync_input_b : link.sync_input_a;
  assign tx_ready = (s.tx.st == SHPFC_TX_IDLE) && clear_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_s = s;
    next_s.rx.valid = 1'b0;
    next_s.pps = sync_in && !s.sync_q;
    next_s.sync_q = sync_in;

    // Transmitter
    case (s.tx.st)
      SHPFC_TX_IDLE: begin
        next_s.tx.line = `SHPFC_LINE_IDLE;
        if (tx_valid && clear_ok) begin
          next_s.tx.shreg = tx_data;
          next_s.tx.tick  = DIV_M1;
          next_s.tx.line  = `SHPFC_START_LVL;
          next_s.tx.st    = SHPFC_TX_START;
        end
      end
      SHPFC_TX_START, SHPFC_TX_DATA: begin
        // Clear is not looked at here, so the byte always completes
        if (s.tx.tick != '0) begin
          next_s.tx.tick = s.tx.tick - 1'b1;
        end else begin
          next_s.tx.tick = DIV_M1;
          if (s.tx.st == SHPFC_TX_DATA && s.tx.bits == `SHPFC_CNT_W'(`SHPFC_DATA_BITS - 1)) begin
            next_s.tx.line = `SHPFC_STOP_LVL;
            next_s.tx.st   = SHPFC_TX_STOP;
          end else begin
            next_s.tx.bits  = (s.tx.st == SHPFC_TX_START) ? '0 : s.tx.bits + 1'b1;
            next_s.tx.line  = s.tx.shreg[0];
            next_s.tx.shreg = s.tx.shreg >> 1;
            next_s.tx.st    = SHPFC_TX_DATA;
          end
        end
      end
      SHPFC_TX_STOP: begin
        if (s.tx.tick != '0) begin
          next_s.tx.tick = s.tx.tick - 1'b1;
        end else begin
          next_s.tx.st = SHPFC_TX_IDLE;
        end
      end
      default: next_s.tx.st = SHPFC_TX_IDLE;
    endcase

    // Receiver
    case (s.rx.st)
      SHPFC_RX_IDLE: begin
        if (!s.hand && line_in == `SHPFC_START_LVL) begin
          next_s.rx.tick = DIV_H;
          next_s.rx.st   = SHPFC_RX_START;
        end
      end
      SHPFC_RX_START, SHPFC_RX_DATA, SHPFC_RX_STOP: begin
        if (s.rx.tick != '0) begin
          next_s.rx.tick = s.rx.tick - 1'b1;
        end else begin
          next_s.rx.tick = DIV_M1;
          case (s.rx.st)
            SHPFC_RX_START: begin
              next_s.rx.bits = '0;
              next_s.rx.st   = (line_in == `SHPFC_START_LVL) ? SHPFC_RX_DATA : SHPFC_RX_IDLE;
            end
            SHPFC_RX_DATA: begin
              next_s.rx.shreg = {line_in, s.rx.shreg[`SHPFC_DATA_BITS-1:1]};
              next_s.rx.bits  = s.rx.bits + 1'b1;
              if (s.rx.bits == `SHPFC_CNT_W'(`SHPFC_DATA_BITS - 1)) begin
                next_s.rx.st = SHPFC_RX_STOP;
              end
            end
            default: begin
              next_s.rx.data      = s.rx.shreg;
              next_s.rx.valid     = 1'b1;
              next_s.rx.frame_err = (line_in != `SHPFC_STOP_LVL);
              next_s.rx.st        = SHPFC_RX_IDLE;
              next_s.hand         = 1'b1;
              next_s.hand_cnt     = HAND_M1;
            end
          endcase
        end
      end
      default: next_s.rx.st = SHPFC_RX_IDLE;
    endcase

    // Hand-off window to the receive store
    if (s.hand) begin
      if (s.hand_cnt != '0) begin
        next_s.hand_cnt = s.hand_cnt - 1'b1;
      end else begin
        next_s.hand = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= '{tx: '{st: SHPFC_TX_IDLE, line: `SHPFC_LINE_IDLE, default: '0},
             rx: '{st: SHPFC_RX_IDLE, default: '0},
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive
  assign link.host_line_tx   = use_uart ? `SHPFC_LINE_IDLE : s.tx.line;
  assign link.uart_line_tx   = use_uart ? s.tx.line : `SHPFC_LINE_IDLE;
  assign link.host_ready_out = (s.rx.st == SHPFC_RX_IDLE) && !s.hand;
  assign link.nav_port_tx    = `SHPFC_LINE_IDLE;
  assign rx_data             = s.rx.data;
  assign rx_valid            = s.rx.valid;
  assign rx_frame_err        = s.rx.frame_err;
  assign pps_pulse           = s.pps;

endmodule

// >>> hw/shpfc_consts.svh
/*
  Constants of the serial host port: baud divisors, frame layout, strobe counts.
  Assumes a 100 MHz system clock; included by package and modules alike.
*/
`ifndef SHPFC_CONSTS_SVH
`define SHPFC_CONSTS_SVH

`define SHPFC_CLK_HZ          100000000
`define SHPFC_BAUD_TYP_HZ     115200
`define SHPFC_BAUD_MIN_HZ     4800
`define SHPFC_HOST_MAX_HZ     1000000
`define SHPFC_UART_MAX_HZ     2000000
`define SHPFC_NAV_MAX_HZ      1000000
`define SHPFC_DIV_W           16
`define SHPFC_DIV_TYP         (`SHPFC_CLK_HZ / `SHPFC_BAUD_TYP_HZ)
`define SHPFC_DATA_BITS       8
`define SHPFC_CNT_W           4
`define SHPFC_HANDOFF_CYC     2
`define SHPFC_LINE_IDLE       1'b1
`define SHPFC_START_LVL       1'b0
`define SHPFC_STOP_LVL        1'b1

`endif

// >>> hw/shpfc_pkg.sv
/*
  Types shared by both ends of the serial host port.
  Assumes shpfc_consts.svh is on the include path.
*/
`include "shpfc_consts.svh"

package shpfc_pkg;

  typedef enum logic [3:0] {
    SHPFC_TX_IDLE  = 4'b0001,
    SHPFC_TX_START = 4'b0010,
    SHPFC_TX_DATA  = 4'b0100,
    SHPFC_TX_STOP  = 4'b1000
  } shpfc_tx_state_t;

  typedef enum logic [3:0] {
    SHPFC_RX_IDLE  = 4'b0001,
    SHPFC_RX_START = 4'b0010,
    SHPFC_RX_DATA  = 4'b0100,
    SHPFC_RX_STOP  = 4'b1000
  } shpfc_rx_state_t;

  typedef struct packed {
    shpfc_tx_state_t              st;
    logic [`SHPFC_DIV_W-1:0]      tick;
    logic [`SHPFC_CNT_W-1:0]      bits;
    logic [`SHPFC_DATA_BITS-1:0]  shreg;
    logic                         line;
  } shpfc_tx_t;

  typedef struct packed {
    shpfc_rx_state_t              st;
    logic [`SHPFC_DIV_W-1:0]      tick;
    logic [`SHPFC_CNT_W-1:0]      bits;
    logic [`SHPFC_DATA_BITS-1:0]  shreg;
    logic [`SHPFC_DATA_BITS-1:0]  data;
    logic                         valid;
    logic                         frame_err;
  } shpfc_rx_t;

endpackage

// >>> hw/shpfc_if.sv
/*
  Link between the device end and the host end: host RS232 channel with flow
  control, logic-level channel, navigation port and two sync inputs.
  Assumes both ends share clk_sys; all lines are plain one-way wires.
*/
`timescale 1ns/10ps

interface shpfc_if;
  logic host_line_tx;
  logic host_line_rx;
  logic host_ready_out;
  logic host_clear_in;
  logic uart_line_tx;
  logic uart_line_rx;
  logic nav_port_tx;
  logic nav_port_rx;
  logic sync_input_a;
  logic sync_input_b;

  modport device (
    output host_line_tx,
    input  host_line_rx,
    output host_ready_out,
    input  host_clear_in,
    output uart_line_tx,
    input  uart_line_rx,
    output nav_port_tx,
    input  nav_port_rx,
    input  sync_input_a,
    input  sync_input_b
  );

  modport host (
    input  host_line_tx,
    output host_line_rx,
    input  host_ready_out,
    output host_clear_in,
    input  uart_line_tx,
    output uart_line_rx,
    input  nav_port_tx,
    output nav_port_rx,
    output sync_input_a,
    output sync_input_b
  );
endinterface

// >>> hw/shpfc_host.sv
/*
  Host end: one 8N1 transmitter and receiver on the RS232 channel, optional
  flow control, plus a plain logic-level channel and a pulse-per-second source.
  Assumes the device end shares clk_sys; baud divisor equals the device's.
*/
`timescale 1ns/10ps

`include "shpfc_consts.svh"

module shpfc_host
  import shpfc_pkg::*;
#(
  parameter int unsigned DIV = `SHPFC_DIV_TYP
) (
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  shpfc_if.host                            link,
  input  wire logic                        use_flow,
  input  wire logic                        use_uart,
  input  wire logic [`SHPFC_DATA_BITS-1:0] tx_data,
  input  wire logic                        tx_valid,
  output logic                             tx_ready,
  output logic [`SHPFC_DATA_BITS-1:0]      rx_data,
  output logic                             rx_valid,
  output logic                             rx_frame_err,
  input  wire logic                        pps
);

  localparam logic [`SHPFC_DIV_W-1:0] DIV_M1 = `SHPFC_DIV_W'(DIV - 1);
  localparam logic [`SHPFC_DIV_W-1:0] DIV_H  = `SHPFC_DIV_W'(DIV / 2);

  typedef struct packed {
    shpfc_tx_t tx;
    shpfc_rx_t rx;
  } shpfc_hst_t;

  shpfc_hst_t s;
  shpfc_hst_t next_s;
  shpfc_tx_t  tx;
  shpfc_rx_t  rx;
  logic       line_in;

  assign tx      = s.tx;
  assign rx      = s.rx;
  assign line_in = use_uart ? link.uart_line_tx : link.host_line_tx;

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter; waits for the device ready level when flow control is on and the RS232 channel is in use
  always_comb begin
    shpfc_tx_t next_tx;
    shpfc_rx_t next_rx;
    next_tx = tx;
    next_rx = rx;
    next_rx.valid = 1'b0;
    tx_ready = (tx.st == SHPFC_TX_IDLE) && (!use_flow || link.host_ready_out || use_uart);
    case (tx.st)
      SHPFC_TX_IDLE: begin
        next_tx.line = `SHPFC_LINE_IDLE;
        if (tx_valid && tx_ready) begin
          next_tx.shreg = tx_data;
          next_tx.tick  = DIV_M1;
          next_tx.line  = `SHPFC_START_LVL;
          next_tx.st    = SHPFC_TX_START;
        end
      end
      SHPFC_TX_START, SHPFC_TX_DATA: begin
        if (tx.tick != '0) begin
          next_tx.tick = tx.tick - 1'b1;
        end else begin
          next_tx.tick = DIV_M1;
          if (tx.st == SHPFC_TX_DATA && tx.bits == `SHPFC_CNT_W'(`SHPFC_DATA_BITS - 1)) begin
            next_tx.line = `SHPFC_STOP_LVL;
            next_tx.st   = SHPFC_TX_STOP;
          end else begin
            next_tx.bits  = (tx.st == SHPFC_TX_START) ? '0 : tx.bits + 1'b1;
            next_tx.line  = tx.shreg[0];
            next_tx.shreg = tx.shreg >> 1;
            next_tx.st    = SHPFC_TX_DATA;
          end
        end
      end
      SHPFC_TX_STOP: begin
        if (tx.tick != '0) begin
          next_tx.tick = tx.tick - 1'b1;
        end else begin
          next_tx.st = SHPFC_TX_IDLE;
        end
      end
      default: next_tx.st = SHPFC_TX_IDLE;
    endcase

    // Receiver; samples mid-bit
    case (rx.st)
      SHPFC_RX_IDLE: begin
        if (line_in == `SHPFC_START_LVL) begin
          next_rx.tick = DIV_H;
          next_rx.st   = SHPFC_RX_START;
        end
      end
      SHPFC_RX_START, SHPFC_RX_DATA, SHPFC_RX_STOP: begin
        if (rx.tick != '0) begin
          next_rx.tick = rx.tick - 1'b1;
        end else begin
          next_rx.tick = DIV_M1;
          case (rx.st)
            SHPFC_RX_START: begin
              next_rx.bits = '0;
              next_rx.st   = (line_in == `SHPFC_START_LVL) ? SHPFC_RX_DATA : SHPFC_RX_IDLE;
            end
            SHPFC_RX_DATA: begin
              next_rx.shreg = {line_in, rx.shreg[`SHPFC_DATA_BITS-1:1]};
              next_rx.bits  = rx.bits + 1'b1;
              if (rx.bits == `SHPFC_CNT_W'(`SHPFC_DATA_BITS - 1)) begin
                next_rx.st = SHPFC_RX_STOP;
              end
            end
            default: begin
              next_rx.data      = rx.shreg;
              next_rx.valid     = 1'b1;
              next_rx.frame_err = (line_in != `SHPFC_STOP_LVL);
              next_rx.st        = SHPFC_RX_IDLE;
            end
          endcase
        end
      end
      default: next_rx.st = SHPFC_RX_IDLE;
    endcase
    next_s = '{tx: next_tx, rx: next_rx};
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s <= '{tx: '{st: SHPFC_TX_IDLE, line: `SHPFC_LINE_IDLE, default: '0},
             rx: '{st: SHPFC_RX_IDLE, default: '0}};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive; clear is held high without flow control
  assign link.host_line_rx  = use_uart ? `SHPFC_LINE_IDLE : tx.line;
  assign link.uart_line_rx  = use_uart ? tx.line : `SHPFC_LINE_IDLE;
  assign link.host_clear_in = use_flow ? (rx.st == SHPFC_RX_IDLE) : 1'b1;
  assign link.nav_port_rx   = `SHPFC_LINE_IDLE;
  assign link.sync_input_a  = pps;
  assign link.sync_input_b  = 1'b0;
  assign rx_data            = rx.data;
  assign rx_valid           = rx.valid;
  assign rx_frame_err       = rx.frame_err;

endmodule

// >>> tb/shpfc_sva.sv
/*
  Checker on the link between device end and host end.
  Assumes one clock for both ends and DIV equal to the ends' divisor.
*/
`timescale 1ns/10ps

`include "shpfc_consts.svh"

module shpfc_sva
  import shpfc_pkg::*;
#(
  parameter int unsigned DIV = `SHPFC_DIV_TYP
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic host_line_tx,
  input  wire logic host_line_rx,
  input  wire logic host_ready_out,
  input  wire logic host_clear_in,
  input  wire logic uart_line_tx
);
  localparam int FR = 10 * DIV;
  localparam int ST = 9 * DIV;
  logic [15:0] tpos;

  ////////////////////////////////////////////////////////////////////////////
  // Position within a frame on the host tx line, 0 while idle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) tpos <= 16'h0000;
    else if (tpos == 0) tpos <= {15'h0000, !host_line_tx};
    else if (tpos == FR - 1) tpos <= 16'h0000;
    else tpos <= tpos + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_start_low: assert property (tpos > 0 && tpos < DIV |-> !host_line_tx)
    else $error("start bit not low");
  chk_stop_high: assert property (tpos >= ST |-> host_line_tx)
    else $error("stop bit not high");
  chk_gap_idle: assert property (tpos == FR - 1 |=> host_line_tx)
    else $error("no idle after stop");
  chk_start_clear: assert property (tpos == 0 && !host_line_tx |-> $past(host_clear_in) || $past(host_clear_in, 2))
    else $error("byte started with clear low");
  chk_busy_rx: assert property ($fell(host_line_rx) |-> ##[1:2] !host_ready_out)
    else $error("ready high during reception");
  chk_ready_end: assert property ($rose(host_ready_out) |-> host_line_rx && $past(host_line_rx))
    else $error("ready rose before stop");
  chk_ready_hold: assert property ($fell(host_ready_out) |-> !host_ready_out [*3])
    else $error("ready low pulse too short");
  chk_reset_idle: assert property ($fell(reset) |-> host_line_tx && uart_line_tx && host_ready_out)
    else $error("lines not idle after reset");
endmodule

// >>> tb/shpfc_tb.sv
/*
  Bench joining device end and host end, driving both user sides.
  Assumes the design files compiled first; divisor shortened to 16.
*/
`timescale 1ns/10ps

module shpfc_tb
  import shpfc_pkg::*;
;
  localparam int unsigned DIV = 16;
  logic       clk_sys  = 1'b0;
  logic       reset    = 1'b1;
  logic       use_flow = 1'b1;
  logic       use_uart = 1'b0;
  logic       sel_b    = 1'b0;
  logic       pps      = 1'b0;
  logic [1:0] txv      = 2'b00;
  logic [7:0] txd [2]  = '{8'h00, 8'h00};
  logic [1:0] txr, rxv, err;
  logic [7:0] d_rxd, h_rxd;
  logic       pps_pulse;
  logic [7:0] dq[$], hq[$];
  int         n_fail = 0, tests_run = 0, n_rose = 0, n_pps = 0;

  shpfc_if link ();
  shpfc_device #(.DIV(DIV), .NAV_DIV(DIV)) shpfc_device_inst (.clk_sys(clk_sys), .reset(reset), .link(link),
    .use_uart(use_uart), .sync_sel_b(sel_b), .tx_data(txd[0]), .tx_valid(txv[0]), .tx_ready(txr[0]),
    .rx_data(d_rxd), .rx_valid(rxv[0]), .rx_frame_err(err[0]), .pps_pulse(pps_pulse));
  shpfc_host #(.DIV(DIV)) shpfc_host_inst (.clk_sys(clk_sys), .reset(reset), .link(link), .use_flow(use_flow),
    .use_uart(use_uart), .tx_data(txd[1]), .tx_valid(txv[1]), .tx_ready(txr[1]),
    .rx_data(h_rxd), .rx_valid(rxv[1]), .rx_frame_err(err[1]), .pps(pps));
  shpfc_sva #(.DIV(DIV)) shpfc_sva_inst (.clk_sys(clk_sys), .reset(reset), .host_line_tx(link.host_line_tx),
    .host_line_rx(link.host_line_rx), .host_ready_out(link.host_ready_out), .host_clear_in(link.host_clear_in),
    .uart_line_tx(link.uart_line_tx));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // End 0 is the device, end 1 the host
  task automatic send(input int e, input logic [7:0] b);
    int i;
    @(negedge clk_sys);
    txd[e] = b;
    txv[e] = 1'b1;
    for (i = 0; i < 4000 && txr[e] !== 1'b1; i++) @(negedge clk_sys);
    @(posedge clk_sys);
    @(negedge clk_sys);
    txv[e] = 1'b0;
  endtask

  task automatic expect_rx(input int e, input logic [7:0] b);
    int i;
    for (i = 0; i < 4000 && (e ? hq.size() : dq.size()) == 0; i++) @(negedge clk_sys);
    if (e) chk(hq.pop_front(), b);
    else chk(dq.pop_front(), b);
  endtask

  // Samples one frame mid-bit on the device's tx line of either channel
  task automatic wire_chk(input logic u, input logic [7:0] b);
    int i;
    logic [9:0] f;
    for (i = 0; i < 4000 && (u ? link.uart_line_tx : link.host_line_tx) !== 1'b0; i++) @(negedge clk_sys);
    repeat (DIV / 2) @(negedge clk_sys);
    for (i = 0; i < 10; i++) begin
      f[i] = u ? link.uart_line_tx : link.host_line_tx;
      repeat (DIV) @(negedge clk_sys);
    end
    chk(f[8:1], b);
    chk({6'h00, f[9], f[0]}, 8'h02);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Sampled mid-cycle, where the one-cycle pulses are settled
  always @(negedge clk_sys) begin
    if (rxv[0] === 1'b1) dq.push_back(d_rxd);
    if (rxv[1] === 1'b1) hq.push_back(h_rxd);
    if (rxv !== 2'b00) chk({6'h00, err & rxv}, 8'h00);
    if (pps_pulse === 1'b1) n_pps++;
  end

  always @(posedge link.host_ready_out) n_rose++;

  initial begin
    #200000;
    n_fail++;
    test_done();
  end

  initial begin
    int i;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    chk({5'h00, link.host_line_tx, link.uart_line_tx, link.host_ready_out}, 8'h07);
    fork
      begin
        send(0, 8'ha5);
        send(0, 8'h3c);
      end
      wire_chk(1'b0, 8'ha5);
      begin
        repeat (3 * DIV) @(negedge clk_sys);
        chk({6'h00, txr[0], link.host_clear_in}, 8'h00);
      end
    join
    expect_rx(1, 8'ha5);
    expect_rx(1, 8'h3c);
    repeat (12 * DIV) @(negedge clk_sys);
    chk({7'h00, hq.size() == 0}, 8'h01);
    n_rose = 0;
    fork
      begin
        send(1, 8'h81);
        send(1, 8'h7e);
      end
      begin
        for (i = 0; i < 4000 && link.host_line_rx !== 1'b0; i++) @(negedge clk_sys);
        repeat (4 * DIV) @(negedge clk_sys);
        chk({7'h00, link.host_ready_out}, 8'h00);
      end
    join
    expect_rx(0, 8'h81);
    expect_rx(0, 8'h7e);
    repeat (2 * DIV) @(negedge clk_sys);
    chk(n_rose[7:0], 8'h02);
    use_flow = 1'b0;
    fork
      send(0, 8'h55);
      begin
        repeat (4 * DIV) @(negedge clk_sys);
        chk({7'h00, link.host_clear_in}, 8'h01);
      end
    join
    expect_rx(1, 8'h55);
    use_uart = 1'b1;
    fork
      send(0, 8'hc3);
      wire_chk(1'b1, 8'hc3);
    join
    expect_rx(1, 8'hc3);
    send(1, 8'h0f);
    expect_rx(0, 8'h0f);
    n_pps = 0;
    for (i = 0; i < 2; i++) begin
      sel_b = i[0];
      pps = 1'b1;
      repeat (4) @(negedge clk_sys);
      pps = 1'b0;
      repeat (4) @(negedge clk_sys);
      chk(n_pps[7:0], 8'h01);
    end
    test_done();
  end
endmodule
